// ==== hdl/decoder_spi_pin_mux.v ====
// Pin function multiplexer for three port C and three port E pads.
// Assumes pads are resolved outside from (out, oe); pad inputs are asynchronous
// and are synchronised here; all control bits come from logic on sys_clk_in.
//
// Summary of operation
// - Port C line 5 defaults to decoder phase B
// - Port C line 5 pull-up on, bit 5 clears
// - Port C line 6 defaults to decoder index
// - Port C line 6 pull-up on, bit 6 clears
// - Port C line 7 defaults to decoder home
// - Port C line 7 pull-up on, bit 7 clears
// - Port C 5..7 alternate: timer A channels 1..3
// - Port E 4..6 default to serial clock/data
// - Port E pull-ups on, bits 4..6 clear each
// - Serial clock driven as master, input as slave
// - Master-out pad drives as master, input slave
// - Master data leads sampling edge by half period
// - Master-in pad input master, driven as slave
// - Unselected slave leaves master-in pad undriven
// - Slave data leads master sampling by half period
// - General-purpose pins individually input or output
// - Slave select tells core transfer is addressed
`timescale 1ns/10ps
`include "pin_mux_regs.vh"

module decoder_spi_pin_mux (
	// Clock and reset
	input  wire       sys_clk_in,
	input  wire       sys_rst_in,
	// Configuration from software
	input  wire       cfg_write_in,
	input  wire [7:0] portc_pullup_enable_in,
	input  wire [7:0] porte_pullup_enable_in,
	input  wire [2:0] portc_func_sel_in,
	input  wire [2:0] portc_alt_sel_in,
	input  wire [2:0] porte_func_sel_in,
	input  wire [2:0] portc_gpio_dir_in,
	input  wire [2:0] portc_gpio_data_in,
	input  wire [2:0] porte_gpio_dir_in,
	input  wire [2:0] porte_gpio_data_in,
	// Port C pads (lines 5, 6, 7 in bits 0, 1, 2)
	input  wire [2:0] portc_pad_in,
	output wire [2:0] portc_pad_out,
	output wire [2:0] portc_pad_oe_out,
	output wire [2:0] portc_pullup_out,
	// Port E pads (lines 4, 5, 6 in bits 0, 1, 2)
	input  wire [2:0] porte_pad_in,
	output wire [2:0] porte_pad_out,
	output wire [2:0] porte_pad_oe_out,
	output wire [2:0] porte_pullup_out,
	// Slave select pad
	input  wire       serial0_slave_select_pin_in,
	// Quadrature decoder 0
	output wire       decoder0_phase_b_in_out,
	output wire       decoder0_index_in_out,
	output wire       decoder0_home_in_out,
	// Timer A channels 1..3
	input  wire [2:0] timer_a_chan_out_in,
	input  wire [2:0] timer_a_chan_oe_in,
	output wire [2:0] timer_a_chan_in_out,
	// Serial core
	input  wire       serial0_master_in,
	input  wire       serial0_clock_out_in,
	input  wire       serial0_master_out_out_in,
	input  wire       serial0_master_in_out_in,
	output wire       serial0_clock_pin_out,
	output wire       serial0_master_out_pin_out,
	output wire       serial0_master_in_pin_out,
	output wire       serial0_selected_out,
	// General-purpose read-back
	output wire [2:0] portc_gpio_read_out,
	output wire [2:0] porte_gpio_read_out
);

	// ****************************************
	// Configuration registers
	// ****************************************
	reg  [2:0] portc_pu_q;
	reg  [2:0] porte_pu_q;
	reg  [2:0] portc_func_q;
	reg  [2:0] portc_alt_q;
	reg  [2:0] porte_func_q;
	reg  [2:0] portc_dir_q;
	reg  [2:0] portc_dat_q;
	reg  [2:0] porte_dir_q;
	reg  [2:0] porte_dat_q;

	// Picks three pull-up enables out of a port-wide byte; other bits are ignored
	function [2:0] gather_pullups;
		input [7:0]   enable;
		input integer pos0;
		input integer pos1;
		input integer pos2;
		begin
			gather_pullups = {enable[pos2], enable[pos1], enable[pos0]};
		end
	endfunction

	// Every field loads on the same strobe, so no half-applied setup reaches a pad
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			portc_pu_q <= 3'h7;
		end else if (cfg_write_in) begin
			portc_pu_q <= gather_pullups(portc_pullup_enable_in, `PORTC_PULLUP_LINE5_BIT,
			                             `PORTC_PULLUP_LINE6_BIT, `PORTC_PULLUP_LINE7_BIT);
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			porte_pu_q <= 3'h7;
		end else if (cfg_write_in) begin
			porte_pu_q <= gather_pullups(porte_pullup_enable_in, `PORTE_PULLUP_LINE4_BIT,
			                             `PORTE_PULLUP_LINE5_BIT, `PORTE_PULLUP_LINE6_BIT);
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			portc_func_q <= `FUNC_SEL_RESET;
		end else if (cfg_write_in) begin
			portc_func_q <= portc_func_sel_in;
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			portc_alt_q <= `ALT_SEL_RESET;
		end else if (cfg_write_in) begin
			portc_alt_q <= portc_alt_sel_in;
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			porte_func_q <= `FUNC_SEL_RESET;
		end else if (cfg_write_in) begin
			porte_func_q <= porte_func_sel_in;
		end
	end

	// Gpio lines come up as inputs; before software asks, only the port E serial pads can be driven
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			portc_dir_q <= `GPIO_DIR_RESET;
		end else if (cfg_write_in) begin
			portc_dir_q <= portc_gpio_dir_in;
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			portc_dat_q <= `GPIO_DATA_RESET;
		end else if (cfg_write_in) begin
			portc_dat_q <= portc_gpio_data_in;
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			porte_dir_q <= `GPIO_DIR_RESET;
		end else if (cfg_write_in) begin
			porte_dir_q <= porte_gpio_dir_in;
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			porte_dat_q <= `GPIO_DATA_RESET;
		end else if (cfg_write_in) begin
			porte_dat_q <= porte_gpio_data_in;
		end
	end

	// ****************************************
	// Pad input synchronisers
	// ****************************************
	// Serial clock is resampled, so the slave path only suits clocks well below 25 MHz
	reg  [2:0] portc_s1_q;
	reg  [2:0] portc_s2_q;
	reg  [2:0] porte_s1_q;
	reg  [2:0] porte_s2_q;
	reg        ss_s1_q;
	reg        ss_s2_q;

	// Synchronisers start high, matching a pulled-up idle pad
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			portc_s1_q <= 3'h7;
			portc_s2_q <= 3'h7;
		end else begin
			portc_s1_q <= portc_pad_in;
			portc_s2_q <= portc_s1_q;
		end
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			porte_s1_q <= 3'h7;
			porte_s2_q <= 3'h7;
		end else begin
			porte_s1_q <= porte_pad_in;
			porte_s2_q <= porte_s1_q;
		end
	end

	// Select idles high, so no slave transfer is seen right after reset
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ss_s1_q <= 1'b1;
			ss_s2_q <= 1'b1;
		end else begin
			ss_s1_q <= serial0_slave_select_pin_in;
			ss_s2_q <= ss_s1_q;
		end
	end

	// ****************************************
	// Port C routing
	// ****************************************
	// Gpio bit overrides the peripheral value; used for both level and enable
	function route_pin;
		input gpio_sel;
		input gpio_val;
		input periph_val;
		begin
			route_pin = gpio_sel ? gpio_val : periph_val;
		end
	endfunction

	wire [2:0] c_is_timer;
	wire [2:0] c_is_dec;
	wire [2:0] c_dec_in;

	// Each line picks its own source, so lines may mix functions freely
	genvar gc;
	generate
		for (gc = 0; gc < 3; gc = gc + 1) begin : g_portc
			assign c_is_timer[gc]          = ~portc_func_q[gc] & portc_alt_q[gc];
			assign c_is_dec[gc]            = ~portc_func_q[gc] & ~portc_alt_q[gc];
			assign portc_pad_out[gc]       = route_pin(portc_func_q[gc], portc_dat_q[gc],
			                                           timer_a_chan_out_in[gc] & c_is_timer[gc]);
			assign portc_pad_oe_out[gc]    = route_pin(portc_func_q[gc], portc_dir_q[gc],
			                                           timer_a_chan_oe_in[gc] & c_is_timer[gc]);
			// Unrouted decoder inputs idle high, as a pulled-up pad would
			assign c_dec_in[gc]            = c_is_dec[gc] ? portc_s2_q[gc] : 1'b1;
			assign timer_a_chan_in_out[gc] = portc_s2_q[gc] & c_is_timer[gc];
		end
	endgenerate

	assign portc_pullup_out        = portc_pu_q;
	assign decoder0_phase_b_in_out = c_dec_in[0];
	assign decoder0_index_in_out   = c_dec_in[1];
	assign decoder0_home_in_out    = c_dec_in[2];
	assign portc_gpio_read_out     = portc_s2_q;

	// ****************************************
	// Port E routing
	// ****************************************
	wire       slave_sel;
	wire [2:0] e_per;
	wire [2:0] e_drv;
	wire [2:0] e_per_val;
	wire [2:0] e_core_in;

	// Select is resampled, so the slave drive follows the pin two cycles late
	assign slave_sel = ~serial0_master_in & ~ss_s2_q;

	// Half-period lead of data over the sampling edge is the core's shift timing
	assign e_drv[0]  = serial0_master_in;
	assign e_drv[1]  = serial0_master_in;
	assign e_drv[2]  = slave_sel;
	assign e_per_val = {serial0_master_in_out_in, serial0_master_out_out_in,
	                    serial0_clock_out_in};

	genvar ge;
	generate
		for (ge = 0; ge < 3; ge = ge + 1) begin : g_porte
			assign e_per[ge]            = ~porte_func_q[ge];
			assign porte_pad_out[ge]    = route_pin(porte_func_q[ge], porte_dat_q[ge],
			                                        e_per_val[ge]);
			assign porte_pad_oe_out[ge] = route_pin(porte_func_q[ge], porte_dir_q[ge],
			                                        e_drv[ge]);
			assign e_core_in[ge]        = e_per[ge] ? porte_s2_q[ge] : 1'b1;
		end
	endgenerate

	assign porte_pullup_out           = porte_pu_q;
	assign serial0_clock_pin_out      = e_core_in[0];
	assign serial0_master_out_pin_out = e_core_in[1];
	assign serial0_master_in_pin_out  = e_core_in[2];
	assign serial0_selected_out       = e_per[0] & slave_sel;
	assign porte_gpio_read_out        = porte_s2_q;

endmodule

// ==== shared/pin_mux_regs.vh ====
// Constants for the decoder and serial pin multiplexer.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH

// ****************************************
// Pull-up enable bit positions
// ****************************************
`define PORTC_PULLUP_LINE5_BIT 5
`define PORTC_PULLUP_LINE6_BIT 6
`define PORTC_PULLUP_LINE7_BIT 7
`define PORTE_PULLUP_LINE4_BIT 4
`define PORTE_PULLUP_LINE5_BIT 5
`define PORTE_PULLUP_LINE6_BIT 6

// ****************************************
// Reset values
// ****************************************
`define PULLUP_ENABLE_RESET   8'hff
`define FUNC_SEL_RESET        3'h0
`define ALT_SEL_RESET         3'h0
`define GPIO_DIR_RESET        3'h0
`define GPIO_DATA_RESET       3'h0

// ****************************************
// Function select codes
// ****************************************
`define FUNC_PERIPH           1'b0
`define FUNC_GPIO             1'b1
`define ALT_DECODER           1'b0
`define ALT_TIMER             1'b1

`endif

// ==== verification/pin_mux_asserts.sv ====
// Port checker for the pin multiplexer.
// Assumes a bind onto decoder_spi_pin_mux; sees its ports only.
`timescale 1ns/10ps
module pin_mux_asserts (
	input wire logic       sys_clk_in, sys_rst_in, cfg_write_in, serial0_master_in,
	input wire logic       serial0_slave_select_pin_in, serial0_selected_out,
	input wire logic [7:0] portc_pullup_enable_in, porte_pullup_enable_in,
	input wire logic [2:0] portc_func_sel_in, portc_alt_sel_in, porte_func_sel_in,
	input wire logic [2:0] portc_gpio_dir_in, timer_a_chan_out_in, timer_a_chan_oe_in,
	input wire logic [2:0] portc_pad_out, portc_pad_oe_out, portc_pullup_out,
	input wire logic [2:0] porte_pullup_out, porte_pad_oe_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	wire w = cfg_write_in && !sys_rst_in;
	property p_rst; $fell(sys_rst_in) |-> portc_pullup_out == 3'h7
		&& porte_pullup_out == 3'h7 && portc_pad_oe_out == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_pc; w |=> portc_pullup_out == $past(portc_pullup_enable_in[7:5]); endproperty
	a_pc: assert property (p_pc) else $error("pull-up c");
	property p_pe; w |=> porte_pullup_out == $past(porte_pullup_enable_in[6:4]); endproperty
	a_pe: assert property (p_pe) else $error("pull-up e");
	property p_tmr; w && portc_func_sel_in == 3'h0 && portc_alt_sel_in == 3'h7 |=>
		portc_pad_oe_out == timer_a_chan_oe_in && portc_pad_out == timer_a_chan_out_in;
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer route");
	property p_gp; w && portc_func_sel_in == 3'h7 |=>
		portc_pad_oe_out == $past(portc_gpio_dir_in); endproperty
	a_gp: assert property (p_gp) else $error("gpio dir");
	property p_mo; w && porte_func_sel_in == 3'h0 |=>
		porte_pad_oe_out[1:0] == {2{serial0_master_in}}; endproperty
	a_mo: assert property (p_mo) else $error("master drive");
	property p_hiz; serial0_slave_select_pin_in [*3] |->
		!porte_pad_oe_out[2] && !serial0_selected_out; endproperty
	a_hiz: assert property (p_hiz) else $error("unselected drive");
	property p_sel; serial0_selected_out || porte_pad_oe_out[2] |-> !serial0_master_in;
	endproperty
	a_sel: assert property (p_sel) else $error("slave only");
endmodule
bind decoder_spi_pin_mux pin_mux_asserts u_chk (.*);

// ==== verification/pad_partner.sv ====
// Far-side pad model: peer drivers, pull-ups and floating lines.
// Assumes the bench sets which lines the peer drives.
`timescale 1ns/10ps
module pad_partner (
	input wire logic       clk_in,
	input wire logic [2:0] drive_in, level_in, dut_out_in, dut_oe_in, pullup_in,
	output logic     [2:0] pad_out
);
	logic [2:0] last_q = 3'h0;
	always @(posedge clk_in) last_q <= pad_out;
	// Undriven, unpulled line flips so a stale value never reads as valid
	always_comb for (int i = 0; i < 3; i++)
		pad_out[i] = dut_oe_in[i] ? dut_out_in[i] : drive_in[i] ? level_in[i]
			: pullup_in[i] ? 1'b1 : !last_q[i];
endmodule

// ==== verification/tb_decoder_spi_pin_mux.sv ====
// Bench for the pin multiplexer.
// Assumes pad_partner models both pad groups.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error %0t: mismatch", $time); end end
`define E @(posedge sys_clk_in)
module tb_decoder_spi_pin_mux;
	logic sys_clk_in = 0, sys_rst_in = 1, cfg_write_in = 0, serial0_master_in = 0;
	logic serial0_slave_select_pin_in = 1, serial0_clock_out_in = 0;
	logic serial0_master_out_out_in = 0, serial0_master_in_out_in = 0;
	logic [7:0] portc_pullup_enable_in = 8'hff, porte_pullup_enable_in = 8'hff;
	logic [2:0] portc_func_sel_in = 0, portc_alt_sel_in = 0, porte_func_sel_in = 0;
	logic [2:0] portc_gpio_dir_in = 0, portc_gpio_data_in = 0, porte_gpio_dir_in = 0;
	logic [2:0] porte_gpio_data_in = 0, timer_a_chan_out_in = 0, timer_a_chan_oe_in = 0;
	logic [2:0] c_drv = 0, c_lvl = 0, e_drv = 0, e_lvl = 0;
	wire [2:0] portc_pad_in, portc_pad_out, portc_pad_oe_out, portc_pullup_out;
	wire [2:0] porte_pad_in, porte_pad_out, porte_pad_oe_out, porte_pullup_out;
	wire [2:0] timer_a_chan_in_out, portc_gpio_read_out, porte_gpio_read_out;
	wire decoder0_phase_b_in_out, decoder0_index_in_out, decoder0_home_in_out;
	wire serial0_clock_pin_out, serial0_master_out_pin_out, serial0_master_in_pin_out;
	wire serial0_selected_out;
	int error_cnt = 0, tests_run = 0;
	decoder_spi_pin_mux u_dut (.*);
	pad_partner u_pc (.clk_in(sys_clk_in), .drive_in(c_drv), .level_in(c_lvl),
		.dut_out_in(portc_pad_out), .dut_oe_in(portc_pad_oe_out),
		.pullup_in(portc_pullup_out), .pad_out(portc_pad_in));
	pad_partner u_pe (.clk_in(sys_clk_in), .drive_in(e_drv), .level_in(e_lvl),
		.dut_out_in(porte_pad_out), .dut_oe_in(porte_pad_oe_out),
		.pullup_in(porte_pullup_out), .pad_out(porte_pad_in));
	initial forever #10 sys_clk_in = ~sys_clk_in;
	// Two sync flops plus one edge of margin
	task wt; repeat (3) `E; #1; endtask
	task wr; cfg_write_in <= 1; `E; cfg_write_in <= 0; `E; #1; endtask
	task end_of_test;
		$display("Checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		end_of_test;
	end
	// ****************
	// Tests
	// ****************
	initial begin
		repeat (16) `E;
		sys_rst_in <= 0; c_drv <= 3'h7; c_lvl <= 3'h5; e_drv <= 3'h3; e_lvl <= 3'h2;
		wt;
		`CHK({decoder0_home_in_out, decoder0_index_in_out, decoder0_phase_b_in_out}, 3'h5)
		`CHK({serial0_master_in_pin_out, serial0_master_out_pin_out,
			serial0_clock_pin_out}, 3'h6)
		$display("Test defaults done");
		for (int i = 0; i < 3; i++) begin
			`E; portc_pullup_enable_in <= ~(8'h20 << i); porte_pullup_enable_in <= ~(8'h10 << i);
			wr;
			`CHK(portc_pullup_out, ~(3'h1 << i))
			`CHK(porte_pullup_out, ~(3'h1 << i))
		end
		$display("Test pull-ups done");
		`E; portc_pullup_enable_in <= 8'hff; portc_alt_sel_in <= 3'h7; c_drv <= 3'h0;
		timer_a_chan_out_in <= 3'h6; timer_a_chan_oe_in <= 3'h3;
		wr;
		`CHK(portc_pad_oe_out, 3'h3)
		wt;
		`CHK(timer_a_chan_in_out, 3'h6)
		`CHK(decoder0_phase_b_in_out, 1'b1)
		$display("Test timer done");
		`E; portc_func_sel_in <= 3'h7; portc_gpio_dir_in <= 3'h5; portc_gpio_data_in <= 3'h4;
		porte_func_sel_in <= 3'h7; porte_gpio_dir_in <= 3'h2; porte_gpio_data_in <= 3'h2;
		wr;
		`CHK(porte_pad_oe_out, 3'h2)
		`CHK(porte_pad_out & 3'h2, 3'h2)
		`CHK(portc_pad_oe_out, 3'h5)
		wt;
		`CHK(portc_gpio_read_out, 3'h6)
		`CHK(porte_gpio_read_out & 3'h3, 3'h2)
		$display("Test gpio done");
		`E; porte_func_sel_in <= 3'h0; serial0_master_in <= 1; serial0_clock_out_in <= 1;
		e_drv <= 3'h0;
		wr;
		`CHK(porte_pad_oe_out, 3'h3)
		`CHK(porte_pad_out & 3'h3, 3'h1)
		`E; serial0_master_in <= 0; serial0_slave_select_pin_in <= 0;
		serial0_master_in_out_in <= 1; e_drv <= 3'h3;
		wt;
		`CHK(porte_pad_oe_out, 3'h4)
		`CHK(serial0_selected_out, 1'b1)
		`E; serial0_slave_select_pin_in <= 1;
		wt;
		`CHK(porte_pad_oe_out, 3'h0)
		$display("Test serial roles done");
		end_of_test;
	end
endmodule
